// ### verilog/pmc_pkg.sv
package pmc_pkg;

  // Register indices on the plain register port
  localparam logic [1:0] PMC_ADDR_CTRL = 2'h0;
  localparam logic [1:0] PMC_ADDR_CMD = 2'h1;
  localparam logic [1:0] PMC_ADDR_STAT = 2'h2;

  // power_mode_control field positions
  localparam int PMC_SLOW_ON_BIT = 7;
  localparam int PMC_FAST_ON_BIT = 6;
  localparam int PMC_TIMER_SLOW_BIT = 5;
  localparam int PMC_CORE_SLOW_BIT = 4;
  localparam int PMC_RSVD_BIT = 3;
  localparam int PMC_WIN_MSB = 2;

  // Power command register field positions
  localparam int PMC_CMD_HALT_BIT = 7;
  localparam int PMC_CMD_IDLE_BIT = 6;

  localparam logic [7:0] PMC_CTRL_RESET = 8'h40;

  // Legal upper nibbles, in sequence order
  localparam logic [3:0] PMC_NIB_HIGH = 4'h4;
  localparam logic [3:0] PMC_NIB_HS_DC = 4'hc;
  localparam logic [3:0] PMC_NIB_DUAL = 4'he;
  localparam logic [3:0] PMC_NIB_DC_LS = 4'hf;
  localparam logic [3:0] PMC_NIB_LOW = 4'hb;

  typedef enum logic [2:0] {
    PMC_MODE_HIGH = 3'b000,
    PMC_MODE_HS_DC = 3'b001,
    PMC_MODE_DUAL = 3'b010,
    PMC_MODE_DC_LS = 3'b011,
    PMC_MODE_LOW = 3'b100,
    PMC_MODE_BAD = 3'b111
  } pmc_mode_e;

  typedef enum logic [0:0] {
    PMC_SW_RUN = 1'b0,
    PMC_SW_WAIT = 1'b1
  } pmc_sw_e;

  typedef struct packed {
    pmc_sw_e state;
    logic sel;
    logic tick;
  } pmc_sw_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic halt;
    logic idle;
    logic [7:0] rdata;
    logic [1:0] fast_sync;
    logic [1:0] slow_sync;
    logic fast_prev;
    logic slow_prev;
    logic [1:0] wake_sync;
    logic wake_prev;
    logic [1:0] opt_sync;
    logic fast_tick;
    logic slow_tick;
    logic core_en;
    logic timer_en;
    logic timer_slow;
    logic core_slow;
  } pmc_state_s;

  function automatic pmc_mode_e pmc_mode_of(input logic [3:0] nib);
    case (nib)
      PMC_NIB_HIGH: pmc_mode_of = PMC_MODE_HIGH;
      PMC_NIB_HS_DC: pmc_mode_of = PMC_MODE_HS_DC;
      PMC_NIB_DUAL: pmc_mode_of = PMC_MODE_DUAL;
      PMC_NIB_DC_LS: pmc_mode_of = PMC_MODE_DC_LS;
      PMC_NIB_LOW: pmc_mode_of = PMC_MODE_LOW;
      default: pmc_mode_of = PMC_MODE_BAD;
    endcase
  endfunction

  // True when nib_new is the same as, or one step from, nib_cur
  function automatic logic pmc_step_ok(input logic [3:0] nib_cur,
                                       input logic [3:0] nib_new);
    logic [2:0] a;
    logic [2:0] b;
    a = pmc_mode_of(nib_cur);
    b = pmc_mode_of(nib_new);
    if (a == PMC_MODE_BAD || b == PMC_MODE_BAD) begin
      pmc_step_ok = 1'b0;
    end else begin
      pmc_step_ok = (a == b) || (a == b + 3'h1) || (b == a + 3'h1);
    end
  endfunction

endpackage

// ### verilog/pmc_clk_switch.sv
`timescale 1ns/1ps
module pmc_clk_switch
  import pmc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic fast_tick_i,
  input wire logic slow_tick_i,
  input wire logic sel_slow_i,
  output logic tick_o,
  output logic slow_active_o
);

  pmc_sw_s q;
  pmc_sw_s next_q;

  // Old source stops at once; the first tick of the new source only
  // aligns, so no period shorter than the new one reaches the core.
  always_comb begin
    next_q = q;
    next_q.tick = 1'b0;
    case (q.state)
      PMC_SW_RUN: begin
        if (sel_slow_i != q.sel) begin
          next_q.state = PMC_SW_WAIT;
          next_q.sel = sel_slow_i;
        end else begin
          next_q.tick = q.sel ? slow_tick_i : fast_tick_i;
        end
      end
      PMC_SW_WAIT: begin
        next_q.sel = sel_slow_i;
        if (sel_slow_i == q.sel && (q.sel ? slow_tick_i : fast_tick_i)) begin
          next_q.state = PMC_SW_RUN;
        end
      end
      default: begin
        next_q.state = PMC_SW_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '{state: PMC_SW_RUN, sel: 1'b0, tick: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign tick_o = q.tick;
  assign slow_active_o = q.sel;

  sw_change_gap_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (q.state == PMC_SW_RUN && sel_slow_i != q.sel) |=> !tick_o [*2])
    else $error("tick passed right after a source change");

  sw_wait_quiet_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (q.state == PMC_SW_WAIT) |=> !tick_o)
    else $error("tick passed while aligning to new source");

endmodule

// ### verilog/pmc_top.sv
// Behaviour
// - Reset loads control register with 40 hex
// - Bit 7 turns slow oscillator on
// - Bit 6 turns fast oscillator on
// - Bit 5 picks idle timer clock source
// - Bit 4 picks core clock source
// - Select pair encodes high, dual, low speed
// - Pair 01 forces low speed
// - Low three bits go to idle timer
// - Upper nibble holds one of five values
// - Non-adjacent step writes are ignored entirely
// - Reset gives high speed; low needs dual
// - HALT stops core clock and fast oscillator
// - Option bit allows or refuses HALT requests
// - IDLE keeps oscillator and timer running
// - Command bit 7 enters HALT
// - Command bit 6 enters IDLE
`timescale 1ns/1ps
module pmc_top
  import pmc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic fast_osc_input_i,
  input wire logic slow_osc_pin_a_i,
  input wire logic halt_option_i,
  input wire logic multi_input_wakeup_i,
  input wire logic idle_exit_i,
  output logic [7:0] reg_rdata_o,
  output logic slow_osc_on_o,
  output logic fast_osc_on_o,
  output logic fast_osc_stop_o,
  output logic idle_timer_slow_o,
  output logic core_clock_slow_o,
  output logic [2:0] idle_window_sel_o,
  output logic core_clk_en_o,
  output logic idle_timer_clk_en_o,
  output logic halt_o,
  output logic idle_o
);

  pmc_state_s q;
  pmc_state_s next_q;
  logic sw_tick;
  logic sw_slow_active;

  pmc_clk_switch u_switch (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .fast_tick_i(q.fast_tick),
    .slow_tick_i(q.slow_tick),
    .sel_slow_i(q.core_slow),
    .tick_o(sw_tick),
    .slow_active_o(sw_slow_active)
  );

  always_comb begin
    logic ctrl_wr;
    logic cmd_wr;
    logic halt_go;
    logic idle_go;
    logic wake_rise;
    logic fast_edge;
    logic slow_edge;
    ctrl_wr = reg_wr_i && (reg_addr_i == PMC_ADDR_CTRL);
    cmd_wr = reg_wr_i && (reg_addr_i == PMC_ADDR_CMD);
    halt_go = cmd_wr && reg_wdata_i[PMC_CMD_HALT_BIT] && q.opt_sync[1];
    idle_go = cmd_wr && reg_wdata_i[PMC_CMD_IDLE_BIT] && !halt_go;
    wake_rise = q.wake_sync[1] && !q.wake_prev;
    fast_edge = q.fast_sync[1] && !q.fast_prev;
    slow_edge = q.slow_sync[1] && !q.slow_prev;
    next_q = q;

    // Oscillator, wake-up and option pins pass two flops before anything looks at them
    next_q.fast_sync = {q.fast_sync[0], fast_osc_input_i};
    next_q.slow_sync = {q.slow_sync[0], slow_osc_pin_a_i};
    next_q.wake_sync = {q.wake_sync[0], multi_input_wakeup_i};
    next_q.opt_sync = {q.opt_sync[0], halt_option_i};
    next_q.fast_prev = q.fast_sync[1];
    next_q.slow_prev = q.slow_sync[1];
    next_q.wake_prev = q.wake_sync[1];

    // Only a legal, adjacent upper nibble is taken; else no change
    if (ctrl_wr && pmc_step_ok(q.ctrl[7:4], reg_wdata_i[7:4])) begin
      next_q.ctrl = {reg_wdata_i[7:4], 1'b0, reg_wdata_i[PMC_WIN_MSB:0]};
    end

    // Power-save entry; a halted or idle core issues no commands
    if (!q.halt && !q.idle) begin
      if (halt_go) begin
        next_q.halt = 1'b1;
      end else if (idle_go) begin
        next_q.idle = 1'b1;
      end
    end
    if (q.halt && wake_rise) begin
      next_q.halt = 1'b0;
    end
    if (q.idle && (wake_rise || idle_exit_i)) begin
      next_q.idle = 1'b0;
    end

    // Fast oscillator held still through HALT
    next_q.fast_tick = fast_edge && q.ctrl[PMC_FAST_ON_BIT]
                       && !q.halt && !next_q.halt;
    next_q.slow_tick = slow_edge && q.ctrl[PMC_SLOW_ON_BIT];

    // Core slow with timer fast is treated as low speed
    next_q.core_slow = q.ctrl[PMC_CORE_SLOW_BIT];
    next_q.timer_slow = q.ctrl[PMC_TIMER_SLOW_BIT]
                        || q.ctrl[PMC_CORE_SLOW_BIT];

    // Idle timer keeps counting in IDLE
    next_q.timer_en = q.timer_slow ? q.slow_tick : q.fast_tick;
    next_q.core_en = sw_tick && !q.halt && !q.idle
                     && !next_q.halt && !next_q.idle;

    next_q.rdata = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        PMC_ADDR_CTRL: next_q.rdata = q.ctrl;
        PMC_ADDR_CMD: next_q.rdata = {q.halt, q.idle, 6'h00};
        PMC_ADDR_STAT: next_q.rdata = {q.halt, q.idle, sw_slow_active,
                                       q.timer_slow, q.core_slow,
                                       q.opt_sync[1], 2'h0};
        default: next_q.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.ctrl <= PMC_CTRL_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign slow_osc_on_o = q.ctrl[PMC_SLOW_ON_BIT];
  assign fast_osc_on_o = q.ctrl[PMC_FAST_ON_BIT];
  assign fast_osc_stop_o = q.halt;
  assign idle_timer_slow_o = q.timer_slow;
  assign core_clock_slow_o = q.core_slow;
  assign idle_window_sel_o = q.ctrl[PMC_WIN_MSB:0];
  assign core_clk_en_o = q.core_en;
  assign idle_timer_clk_en_o = q.timer_en;
  assign halt_o = q.halt;
  assign idle_o = q.idle;

  reset_value_a: assert property (
    @(posedge core_clk_i) disable iff (1'b0)
    sys_rst_i |-> (q.ctrl == PMC_CTRL_RESET && !halt_o && !idle_o))
    else $error("control register not at reset value");

  high_after_reset_a: assert property (
    @(posedge core_clk_i) disable iff (1'b0)
    sys_rst_i |-> (pmc_mode_of(q.ctrl[7:4]) == PMC_MODE_HIGH))
    else $error("reset did not give high speed mode");

  legal_nibble_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    pmc_mode_of(q.ctrl[7:4]) != PMC_MODE_BAD)
    else $error("upper nibble holds an illegal value");

  adjacent_step_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    ##1 pmc_step_ok($past(q.ctrl[7:4]), q.ctrl[7:4]))
    else $error("mode moved by more than one step");

  no_low_to_high_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (pmc_mode_of(q.ctrl[7:4]) == PMC_MODE_LOW)
      |=> (pmc_mode_of(q.ctrl[7:4]) != PMC_MODE_HIGH))
    else $error("high speed reached straight from low speed");

  bad_write_kept_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_wr_i && reg_addr_i == PMC_ADDR_CTRL
      && !pmc_step_ok(q.ctrl[7:4], reg_wdata_i[7:4]))
      |=> $stable(q.ctrl))
    else $error("ignored write changed the register");

  slow_on_write_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_wr_i && reg_addr_i == PMC_ADDR_CTRL
      && pmc_step_ok(q.ctrl[7:4], reg_wdata_i[7:4]))
      |=> (slow_osc_on_o == $past(reg_wdata_i[PMC_SLOW_ON_BIT])
           && fast_osc_on_o == $past(reg_wdata_i[PMC_FAST_ON_BIT])))
    else $error("accepted write not seen on oscillator enables");

  window_pass_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_wr_i && reg_addr_i == PMC_ADDR_CTRL
      && pmc_step_ok(q.ctrl[7:4], reg_wdata_i[7:4]))
      |=> (idle_window_sel_o == $past(reg_wdata_i[PMC_WIN_MSB:0])))
    else $error("window select not passed through");

  force_low_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    core_clock_slow_o |-> idle_timer_slow_o)
    else $error("core slow while idle timer fast");

  timer_source_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (q.timer_slow && q.slow_tick) |=> idle_timer_clk_en_o)
    else $error("idle timer missed a slow tick");

  core_source_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    ##1 (core_clock_slow_o == $past(q.ctrl[PMC_CORE_SLOW_BIT])))
    else $error("core select does not follow register");

  halt_enter_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_wr_i && reg_addr_i == PMC_ADDR_CMD
      && reg_wdata_i[PMC_CMD_HALT_BIT] && q.opt_sync[1]
      && !halt_o && !idle_o) |=> halt_o)
    else $error("halt command not taken");

  halt_refused_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_wr_i && reg_addr_i == PMC_ADDR_CMD
      && !q.opt_sync[1] && !halt_o) |=> !halt_o)
    else $error("halt entered while option disallows it");

  idle_enter_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_wr_i && reg_addr_i == PMC_ADDR_CMD
      && reg_wdata_i[PMC_CMD_IDLE_BIT] && !reg_wdata_i[PMC_CMD_HALT_BIT]
      && !halt_o && !idle_o) |=> idle_o)
    else $error("idle command not taken");

  halt_stops_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    halt_o |=> (!core_clk_en_o && !q.fast_tick && fast_osc_stop_o
                || !halt_o))
    else $error("clock ran during halt");

  idle_core_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (idle_o && q.fast_tick && !q.timer_slow)
      |=> (!core_clk_en_o && idle_timer_clk_en_o))
    else $error("idle state gated the wrong clock");

  rsvd_zero_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !q.ctrl[PMC_RSVD_BIT])
    else $error("reserved bit stored as one");

  ctrl_read_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_rd_i && reg_addr_i == PMC_ADDR_CTRL)
      |=> (reg_rdata_o == $past(q.ctrl)))
    else $error("control read returned wrong data");

  cmd_read_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_rd_i && reg_addr_i == PMC_ADDR_CMD)
      |=> (reg_rdata_o == {$past(halt_o), $past(idle_o), 6'h00}))
    else $error("command read returned wrong data");

  fast_gate_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !fast_osc_on_o |=> !q.fast_tick)
    else $error("fast tick while fast oscillator off");

  slow_gate_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !slow_osc_on_o |=> !q.slow_tick)
    else $error("slow tick while slow oscillator off");

  timer_fast_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!q.timer_slow && q.fast_tick) |=> idle_timer_clk_en_o)
    else $error("idle timer missed a fast tick");

  timer_other_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (q.timer_slow && !q.slow_tick) |=> !idle_timer_clk_en_o)
    else $error("idle timer ticked from the fast clock");

  high_mode_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (pmc_mode_of(q.ctrl[7:4]) == PMC_MODE_HIGH)
      |=> (!core_clock_slow_o && !idle_timer_slow_o))
    else $error("high speed mode did not select fast clocks");

  dual_mode_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (pmc_mode_of(q.ctrl[7:4]) == PMC_MODE_DUAL)
      |=> (!core_clock_slow_o && idle_timer_slow_o))
    else $error("dual clock mode selected the wrong clocks");

  low_mode_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (pmc_mode_of(q.ctrl[7:4]) == PMC_MODE_LOW)
      |=> (core_clock_slow_o && idle_timer_slow_o))
    else $error("low speed mode did not select slow clocks");

  switch_gate_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !sw_tick |=> !core_clk_en_o)
    else $error("core enable without a switch tick");

  idle_core_off_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    idle_o |=> !core_clk_en_o)
    else $error("core clock ran during idle");

  idle_exit_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (idle_o && idle_exit_i) |=> !idle_o)
    else $error("idle timer exit not taken");

  halt_wake_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (halt_o && q.wake_sync[1] && !q.wake_prev) |=> !halt_o)
    else $error("wake-up edge did not end halt");

  halt_no_idle_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (halt_o && !idle_o) |=> !idle_o)
    else $error("command taken while halted");

  idle_no_halt_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (idle_o && !halt_o) |=> !halt_o)
    else $error("command taken while idle");

endmodule

// ### test/test_dual_clock_power_mode_control.sv
`timescale 1ns/1ps
module test_dual_clock_power_mode_control;
  import pmc_pkg::*;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fpin = 1'b0;
  logic spin = 1'b0;
  logic hopt = 1'b0;
  logic wake = 1'b0;
  logic iexit = 1'b0;
  logic [7:0] rdata;
  logic slow_on, fast_on, fast_stop, t_slow, c_slow;
  logic core_en, tmr_en, halt, idle;
  logic [2:0] win;
  int bad_count = 0;
  int n_tests = 0;
  int ccnt = 0;
  int tcnt = 0;
  int ccnt_all = 0;
  int tcnt_all = 0;
  int ph = 0;

  pmc_top DUT (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .reg_addr_i(addr),
    .reg_wdata_i(wdata),
    .reg_wr_i(wr),
    .reg_rd_i(rd),
    .fast_osc_input_i(fpin),
    .slow_osc_pin_a_i(spin),
    .halt_option_i(hopt),
    .multi_input_wakeup_i(wake),
    .idle_exit_i(iexit),
    .reg_rdata_o(rdata),
    .slow_osc_on_o(slow_on),
    .fast_osc_on_o(fast_on),
    .fast_osc_stop_o(fast_stop),
    .idle_timer_slow_o(t_slow),
    .core_clock_slow_o(c_slow),
    .idle_window_sel_o(win),
    .core_clk_en_o(core_en),
    .idle_timer_clk_en_o(tmr_en),
    .halt_o(halt),
    .idle_o(idle)
  );

  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end

  // Pins toggle slower than the two-flop sync needs
  always @(posedge core_clk_i) begin
    ph <= ph + 1;
    if (ph % 3 == 0) fpin <= ~fpin;
    if (ph % 4 == 0) spin <= ~spin;
    if (core_en === 1'b1) ccnt_all <= ccnt_all + 1;
    if (tmr_en === 1'b1) tcnt_all <= tcnt_all + 1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
    @(negedge core_clk_i);
  endtask

  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    @(negedge core_clk_i);
    d = rdata;
  endtask

  task automatic expect_reg(input logic [1:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    check(d, e);
  endtask

  task automatic count_ticks(input int n);
    int c0;
    int t0;
    @(negedge core_clk_i);
    c0 = ccnt_all;
    t0 = tcnt_all;
    repeat (n) @(negedge core_clk_i);
    ccnt = ccnt_all - c0;
    tcnt = tcnt_all - t0;
  endtask

  task automatic t_reset;
    expect_reg(PMC_ADDR_CTRL, 8'h40);
    check({slow_on, fast_on, t_slow, c_slow, 1'b0, win}, 8'h40);
    check({fast_stop, halt, idle}, 8'h00);
    count_ticks(40);
    check({ccnt > 0, tcnt > 0}, 8'h03);
  endtask

  task automatic t_walk;
    wr_reg(PMC_ADDR_CTRL, 8'hc5);
    expect_reg(PMC_ADDR_CTRL, 8'hc5);
    check({slow_on, win}, 8'h0d);
    // Slow oscillator given time to settle before the timer uses it
    repeat (16) @(posedge core_clk_i);
    wr_reg(PMC_ADDR_CTRL, 8'he5);
    expect_reg(PMC_ADDR_CTRL, 8'he5);
    check({t_slow, c_slow}, 8'h02);
    // Reserved bit written as one must not be stored
    wr_reg(PMC_ADDR_CTRL, 8'hfd);
    expect_reg(PMC_ADDR_CTRL, 8'hf5);
    check({t_slow, c_slow}, 8'h03);
    wr_reg(PMC_ADDR_CTRL, 8'hb5);
    expect_reg(PMC_ADDR_CTRL, 8'hb5);
    check({slow_on, fast_on}, 8'h02);
    count_ticks(60);
    check({ccnt > 0, tcnt > 0}, 8'h03);
    expect_reg(PMC_ADDR_STAT, 8'h38);
  endtask

  task automatic t_refuse;
    logic [7:0] bad [5] = '{8'h40, 8'hc0, 8'he5, 8'h75, 8'h05};
    logic [7:0] back [4] = '{8'hf5, 8'he5, 8'hc5, 8'h45};
    foreach (bad[i]) begin
      wr_reg(PMC_ADDR_CTRL, bad[i]);
      expect_reg(PMC_ADDR_CTRL, 8'hb5);
    end
    check({t_slow, c_slow}, 8'h03);
    foreach (back[i]) begin
      repeat (16) @(posedge core_clk_i);
      wr_reg(PMC_ADDR_CTRL, back[i]);
      expect_reg(PMC_ADDR_CTRL, back[i]);
    end
    check({slow_on, fast_on, t_slow, c_slow}, 8'h04);
    wr_reg(2'h3, 8'hff);
    expect_reg(2'h3, 8'h00);
    expect_reg(PMC_ADDR_CTRL, 8'h45);
  endtask

  task automatic t_halt;
    int i;
    wr_reg(PMC_ADDR_CMD, 8'h80);
    check({halt, idle}, 8'h00);
    @(posedge core_clk_i);
    hopt <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    wr_reg(PMC_ADDR_CMD, 8'h80);
    check({halt, fast_stop, idle}, 8'h06);
    expect_reg(PMC_ADDR_CMD, 8'h80);
    count_ticks(30);
    check(8'(ccnt > 0), 8'h00);
    // Commands while halted are dropped
    wr_reg(PMC_ADDR_CMD, 8'h40);
    check({halt, idle}, 8'h02);
    expect_reg(PMC_ADDR_CTRL, 8'h45);
    @(posedge core_clk_i);
    wake <= 1'b1;
    for (i = 0; i < 10 && halt !== 1'b0; i++) @(negedge core_clk_i);
    check({halt, fast_stop}, 8'h00);
    @(posedge core_clk_i);
    wake <= 1'b0;
  endtask

  task automatic t_idle;
    hopt <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    wr_reg(PMC_ADDR_CMD, 8'hc0);
    check({halt, idle}, 8'h01);
    count_ticks(40);
    check(8'(ccnt > 0), 8'h00);
    check({tcnt > 0, fast_on, fast_stop}, 8'h06);
    expect_reg(PMC_ADDR_CTRL, 8'h45);
    @(posedge core_clk_i);
    iexit <= 1'b1;
    @(posedge core_clk_i);
    iexit <= 1'b0;
    @(negedge core_clk_i);
    check(idle, 8'h00);
  endtask

  task automatic t_rereset;
    wr_reg(PMC_ADDR_CTRL, 8'hc7);
    wr_reg(PMC_ADDR_CTRL, 8'he7);
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    expect_reg(PMC_ADDR_CTRL, 8'h40);
    check({slow_on, t_slow, win}, 8'h00);
  endtask

  task automatic conclude;
    $display("mismatches %0d, comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  initial begin
    #200000;
    bad_count++;
    conclude();
  end

  initial begin
    // Rising edge at time zero so the asynchronous reset really fires
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_walk();
    t_refuse();
    t_halt();
    t_idle();
    t_rereset();
    conclude();
  end
endmodule
